// file: hw/ecw_capture_unit.sv
`timescale 1ns/100ps
package ecw_pkg;
  // ----------------------------------------------------------------
  // Control word layout
  // ----------------------------------------------------------------
  localparam int unsigned CTL_W        = 16;
  localparam int unsigned FUNC_N       = 4;
  localparam int unsigned FUNC_LSB     = 0;
  localparam int unsigned CMD_LSB      = 4;
  localparam int unsigned CMD_W        = 3;
  localparam int unsigned MODE_BIT     = 7;
  localparam int unsigned ABS_BIT      = 13;
  localparam int unsigned PARK_BIT     = 14;
  localparam int unsigned ACK_BIT      = 15;
  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int unsigned ST_ACT_LSB   = 0;
  localparam int unsigned ST_AVL_LSB   = 4;
  localparam int unsigned ST_ABS_BIT   = 13;
  localparam int unsigned ST_PARK_BIT  = 14;
  localparam int unsigned ST_ERR_BIT   = 15;
  // ----------------------------------------------------------------
  // Defaults and reset values
  // ----------------------------------------------------------------
  localparam int unsigned POS_W        = 32;
  localparam int unsigned FINE_W       = 4;
  localparam int unsigned FINE_MAX     = 15;
  localparam logic [15:0] STATUS_RST   = 16'h0000;
  localparam logic [3:0]  FUNC_RST     = 4'h0;

  typedef enum logic [2:0] {
    CMD_NONE     = 3'b000,
    CMD_ACTIVATE = 3'b001,
    CMD_READ     = 3'b010,
    CMD_TERM     = 3'b011
  } ecw_cmd_t;
endpackage

module ecw_capture_unit #(
  parameter int unsigned PW = 32
) (
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire logic          arm,
  input  wire logic          term,
  input  wire logic          edgeFall,
  input  wire logic          sigIn,
  input  wire logic [PW-1:0] position,
  output logic               active,
  output logic               available,
  output logic [PW-1:0]      value
);
  import ecw_pkg::*;

  logic          active_ff;
  logic          avail_ff;
  logic          sigPrev_ff;
  logic [PW-1:0] value_ff;
  wire           edgeSeen = edgeFall ? (sigPrev_ff & ~sigIn)
                                     : (~sigPrev_ff & sigIn);
  wire           hit      = active_ff & edgeSeen & ~arm & ~term;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      active_ff  <= 1'b0;
      avail_ff   <= 1'b0;
      sigPrev_ff <= 1'b0;
      value_ff   <= '0;
    end else begin
      sigPrev_ff <= sigIn;
      if (term) begin
        active_ff <= 1'b0;
        avail_ff  <= 1'b0;
      end else if (arm) begin
        // Re-arming discards an older captured value
        active_ff <= 1'b1;
        avail_ff  <= 1'b0;
      end else if (hit) begin
        active_ff <= 1'b0;
        avail_ff  <= 1'b1;
        value_ff  <= position;
      end
    end
  end

  assign active    = active_ff;
  assign available = avail_ff;
  assign value     = value_ff;
endmodule // ecw_capture_unit

// file: hw/ecw_control_word.sv
`timescale 1ns/100ps
// Function
// - Mode 0: bits 0-3 request reference marks 1-4
// - Mode 1: bits 0-3 request probe edges
// - Select bit one requests its function
// - Multi-activate withholds values until selects clear
// - Rising and falling captures armed together
// - Bit 7 selects mode; fine resolution applies
// - Bit 13 requests cyclic absolute value
// - Bit 14 parking request, acknowledged in status
// - Status 0-3 active, 4-7 values available
module ecw_control_word #(
  parameter int unsigned PW = ecw_pkg::POS_W
) (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire logic [ecw_pkg::CTL_W-1:0] encoderControlWord,
  input  wire logic                      controlWordValid,
  input  wire logic [ecw_pkg::FINE_W-1:0] fineResolutionSetting,
  input  wire logic [PW-1:0]             positionActual,
  input  wire logic [3:0]                refMarkPin,
  input  wire logic [3:0]                probePin,
  input  wire logic                      encoderFaultPin,
  output logic [ecw_pkg::CTL_W-1:0]      encoderStatusWord,
  output logic [PW-1:0]                  readValue,
  output logic [1:0]                     readIndex,
  output logic                           readValid,
  output logic                           absCyclicRequest,
  output logic                           parkRequest,
  output logic                           errorAckPulse
);
  import ecw_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [8:0] syncA_ff;
  logic [8:0] syncB_ff;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= {encoderFaultPin, probePin, refMarkPin};
      syncB_ff <= syncA_ff;
    end
  end
  wire [3:0] refSync   = syncB_ff[3:0];
  wire [3:0] probeSync = syncB_ff[7:4];
  wire       faultSync = syncB_ff[8];

  // ----------------------------------------------------------------
  // Control word decode
  // ----------------------------------------------------------------
  wire [3:0]  funcSel  = encoderControlWord[FUNC_LSB +: FUNC_N];
  wire [2:0]  cmdField = encoderControlWord[CMD_LSB +: CMD_W];
  wire        modeProbe = encoderControlWord[MODE_BIT];
  // Bits 8..12 are never looked at
  wire        cmdAct   = controlWordValid
                         & (cmdField == CMD_ACTIVATE);
  wire        cmdRead  = controlWordValid & (cmdField == CMD_READ);
  wire        cmdTerm  = controlWordValid & (cmdField == CMD_TERM);
  wire [3:0]  armVec   = cmdAct  ? funcSel : 4'h0;
  wire [3:0]  termVec  = cmdTerm ? funcSel : 4'h0;
  wire        multiSel = (funcSel != 4'h0) &&
                         ((funcSel & (funcSel - 4'h1)) != 4'h0);

  // Mode is latched at activation so a later mode flip cannot
  // redirect an armed capture onto the other input
  logic [3:0] modeProbe_ff;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      modeProbe_ff <= FUNC_RST;
    end else begin
      for (int i = 0; i < FUNC_N; i++) begin
        if (armVec[i]) begin
          modeProbe_ff[i] <= modeProbe;
        end
      end
    end
  end

  // Fine resolution: drop the unused fine bits of the position
  wire [FINE_W-1:0] fineShift = FINE_W'(FINE_MAX) - fineResolutionSetting;
  wire [PW-1:0]     scaledPos = positionActual >> fineShift;

  // ----------------------------------------------------------------
  // Capture functions
  // ----------------------------------------------------------------
  wire [3:0]    funcActive;
  wire [3:0]    funcAvail;
  wire [PW-1:0] funcValue [4];

  for (genvar g = 0; g < FUNC_N; g++) begin : g_func
    // Probe mode: functions 1 and 3 rising, 2 and 4 falling
    // Reference mode: each function watches its own mark
    // The new mode picks the input already in the arming cycle, so the
    // edge history never spans a switch of source (no false capture)
    wire useProbe = armVec[g] ? modeProbe : modeProbe_ff[g];
    wire sigSel   = useProbe ? probeSync[g] : refSync[g];
    // Each function has its own unit, so a rising and a falling
    // capture never cancel one another
    ecw_capture_unit #(.PW(PW)) u_cap (
      .clock     (clock),
      .rstn      (rstn),
      .arm       (armVec[g]),
      .term      (termVec[g]),
      .edgeFall  (useProbe & (g % 2 == 1)),
      .sigIn     (sigSel),
      .position  (scaledPos),
      .active    (funcActive[g]),
      .available (funcAvail[g]),
      .value     (funcValue[g])
    );
  end

  // ----------------------------------------------------------------
  // Value release after multiple activation
  // ----------------------------------------------------------------
  logic [3:0] actSet_ff;
  logic       multi_ff;
  logic       released_ff;
  wire        selCleared = controlWordValid & ((funcSel & actSet_ff) == 4'h0);
  wire        readOk     = ~multi_ff | released_ff | selCleared;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      actSet_ff   <= FUNC_RST;
      multi_ff    <= 1'b0;
      released_ff <= 1'b0;
    end else if (cmdAct) begin
      actSet_ff   <= funcSel;
      multi_ff    <= multiSel;
      released_ff <= 1'b0;
    end else if (selCleared) begin
      released_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read value
  // ----------------------------------------------------------------
  wire [3:0] readCand = funcSel & funcAvail;
  wire [1:0] pickIdx  = readCand[0] ? 2'h0 :
                        readCand[1] ? 2'h1 :
                        readCand[2] ? 2'h2 : 2'h3;
  wire       readGo   = cmdRead & (readCand != 4'h0) & readOk;

  logic [PW-1:0] readValue_ff;
  logic [1:0]    readIndex_ff;
  logic          readValid_ff;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      readValue_ff <= '0;
      readIndex_ff <= 2'h0;
      readValid_ff <= 1'b0;
    end else begin
      readValid_ff <= readGo;
      if (readGo) begin
        readValue_ff <= funcValue[pickIdx];
        readIndex_ff <= pickIdx;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cyclic value, parking, error acknowledge
  // ----------------------------------------------------------------
  logic abs_ff;
  logic park_ff;
  logic ackPrev_ff;
  logic errAck_ff;
  logic errPend_ff;
  wire  ackRise = controlWordValid & encoderControlWord[ACK_BIT] & ~ackPrev_ff;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      abs_ff     <= 1'b0;
      park_ff    <= 1'b0;
      ackPrev_ff <= 1'b0;
      errAck_ff  <= 1'b0;
      errPend_ff <= 1'b0;
    end else begin
      errAck_ff <= ackRise;
      if (controlWordValid) begin
        abs_ff     <= encoderControlWord[ABS_BIT];
        park_ff    <= encoderControlWord[PARK_BIT];
        ackPrev_ff <= encoderControlWord[ACK_BIT];
      end
      // A fault still present wins over the acknowledge
      if (faultSync) begin
        errPend_ff <= 1'b1;
      end else if (ackRise) begin
        errPend_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  logic [CTL_W-1:0] status_ff;
  wire  [3:0]       availShown = readOk ? funcAvail : 4'h0;
  wire  [CTL_W-1:0] nxt_status = {errPend_ff, park_ff, abs_ff, 5'h00,
                                  availShown, funcActive};
  always_ff @(posedge clock) begin
    if (!rstn) begin
      status_ff <= STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign encoderStatusWord = status_ff;
  assign readValue         = readValue_ff;
  assign readIndex         = readIndex_ff;
  assign readValid         = readValid_ff;
  assign absCyclicRequest  = abs_ff;
  assign parkRequest       = park_ff;
  assign errorAckPulse     = errAck_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  activate_arms_a: assert property (
    cmdAct && funcSel[0] |=> ##1 encoderStatusWord[0])
    else $error("activate did not show function 1 active");
  terminate_clears_a: assert property (
    cmdTerm && funcSel[1] |=> ##1 !encoderStatusWord[1]
                                  && !encoderStatusWord[5])
    else $error("terminate left function 2 in status");
  read_withheld_a: assert property (
    cmdRead && multi_ff && !released_ff && !selCleared |=> !readValid)
    else $error("value read before selects released");
  read_pulse_a: assert property (
    readValid |-> $past(cmdRead)
                  && ($past(funcSel) & (4'h1 << readIndex)) != 4'h0)
    else $error("read valid without a read of that function");
  abs_follow_a: assert property (
    controlWordValid |=> absCyclicRequest == $past(encoderControlWord[13]))
    else $error("cyclic absolute request not taken");
  park_handshake_a: assert property (
    controlWordValid && encoderControlWord[14] && !$past(parkRequest)
    |=> parkRequest ##1 encoderStatusWord[14])
    else $error("parking not acknowledged");
  err_ack_a: assert property (
    errPend_ff && ackRise && !faultSync |=> !errPend_ff ##1
                                             !encoderStatusWord[15])
    else $error("error acknowledge missed");
  mode_latch_a: assert property (
    cmdAct && funcSel[2] |=> modeProbe_ff[2] == $past(modeProbe))
    else $error("mode not latched at activation");
  dual_arm_a: assert property (
    cmdAct && modeProbe && funcSel[1:0] == 2'b11
    |=> ##1 encoderStatusWord[1:0] == 2'b11)
    else $error("rising and falling not armed together");
endmodule // ecw_control_word

// file: bench/ecw_host_model.sv
`timescale 1ns/100ps
module ecw_host_model (
  input  wire logic                 clock,
  output logic [ecw_pkg::CTL_W-1:0] encoderControlWord,
  output logic                      controlWordValid
);
  import ecw_pkg::*;
  initial begin
    encoderControlWord = '0;
    controlWordValid   = 1'b0;
  end
  // ----------------------------------------------------------------
  // Cyclic telegram
  // ----------------------------------------------------------------
  // Outside a telegram the lines carry the inverted word, so a design
  // that samples without the valid strobe sees garbage, not a copy
  task automatic sendWord(input logic [CTL_W-1:0] word);
    @(negedge clock);
    encoderControlWord <= word;
    controlWordValid   <= 1'b1;
    @(negedge clock);
    encoderControlWord <= ~word;
    controlWordValid   <= 1'b0;
  endtask
endmodule // ecw_host_model

// file: bench/test_encoder_control_word_handler.sv
`timescale 1ns/100ps
module test_encoder_control_word_handler;
  import ecw_pkg::*;
  logic              clock    = 1'b0;
  logic              rstn     = 1'b0;
  logic [CTL_W-1:0]  ctlWord;
  logic              ctlValid;
  logic [FINE_W-1:0] fineSet  = '0;
  logic [31:0]       position = '0;
  logic [3:0]        refPin   = 4'h0;
  logic [3:0]        probePin = 4'hA;
  logic              faultPin = 1'b0;
  logic [15:0]       statusWord;
  logic [31:0]       readValue;
  logic [1:0]        readIndex;
  logic              readValid, absReq, parkReq, errAck;
  logic [34:0]       notes[$];
  logic [34:0]       seen, exp;
  int                failures = 0, checksDone = 0, cycles = 0;

  always #4 clock = ~clock;

  ecw_host_model host (.clock(clock), .encoderControlWord(ctlWord),
    .controlWordValid(ctlValid));

  ecw_control_word #(.PW(32)) dut (.clock(clock), .rstn(rstn),
    .encoderControlWord(ctlWord), .controlWordValid(ctlValid),
    .fineResolutionSetting(fineSet), .positionActual(position),
    .refMarkPin(refPin), .probePin(probePin), .encoderFaultPin(faultPin),
    .encoderStatusWord(statusWord), .readValue(readValue),
    .readIndex(readIndex), .readValid(readValid), .absCyclicRequest(absReq),
    .parkRequest(parkReq), .errorAckPulse(errAck));

  task automatic check(input string what, input logic [34:0] got,
                       input logic [34:0] want);
    checksDone++;
    if (got !== want) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, want, got);
    end
  endtask

  task automatic results();
    if (failures == 0 && checksDone > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic expectStatus(input logic [15:0] want);
    repeat (7) @(negedge clock);
    check("status", {19'h0, statusWord}, {19'h0, want});
  endtask

  function automatic logic [31:0] fineVal();
    fineVal = position >> (FINE_MAX - 32'(fineSet));
  endfunction

  // ----------------------------------------------------------------
  // Result watch
  // ----------------------------------------------------------------
  // A pulse with no note pending compares against its own inverse,
  // which is how a read that should have been refused shows up
  always @(negedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      results();
    end
    if (readValid === 1'b1 || errAck === 1'b1) begin
      seen = (readValid === 1'b1) ? {1'b0, readIndex, readValue}
                                  : {1'b1, 34'h0};
      exp = (notes.size() > 0) ? notes.pop_front() : ~seen;
      check("result", seen, exp);
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h5026));
    position = $urandom;
    fineSet  = 4'($urandom);
    repeat (16) @(negedge clock);
    rstn <= 1'b1;
    expectStatus(16'h0000);
    host.sendWord(16'h7F00);
    expectStatus(16'h6000);
    check("abs park", {33'h0, absReq, parkReq}, 35'h3);
    host.sendWord(16'h0013);
    expectStatus(16'h0003);
    refPin <= 4'h1;
    expectStatus(16'h0002);
    host.sendWord(16'h0021);
    expectStatus(16'h0002);
    host.sendWord(16'h0000);
    expectStatus(16'h0012);
    notes.push_back({1'b0, 2'd0, fineVal()});
    host.sendWord(16'h0021);
    host.sendWord(16'h0032);
    expectStatus(16'h0010);
    host.sendWord(16'h0093);
    expectStatus(16'h0003);
    probePin <= 4'h9;
    expectStatus(16'h0000);
    host.sendWord(16'h0000);
    expectStatus(16'h0030);
    notes.push_back({1'b0, 2'd1, fineVal()});
    host.sendWord(16'h0022);
    notes.push_back({1'b0, 2'd0, fineVal()});
    host.sendWord(16'h0023);
    faultPin <= 1'b1;
    expectStatus(16'h8030);
    faultPin <= 1'b0;
    repeat (4) @(negedge clock);
    notes.push_back({1'b1, 34'h0});
    host.sendWord(16'h8000);
    expectStatus(16'h0030);
    host.sendWord(16'h8000);
    host.sendWord(16'h0000);
    // Functions 3 and 4 on fresh positions, reference then probe
    for (int pass = 0; pass < 2; pass++) begin
      position <= $urandom;
      fineSet  <= 4'($urandom);
      host.sendWord((pass == 0) ? 16'h001C : 16'h009C);
      expectStatus(16'h000C);
      if (pass == 0) begin
        refPin <= 4'hF;
      end else begin
        probePin <= 4'h5;
      end
      expectStatus(16'h0000);
      host.sendWord(16'h0000);
      expectStatus(16'h00F0);
      host.sendWord(16'h00F1);
      expectStatus(16'h00F0);
      notes.push_back({1'b0, 2'h2, fineVal()});
      host.sendWord(16'h0024);
      notes.push_back({1'b0, 2'h3, fineVal()});
      host.sendWord(16'h0028);
    end
    repeat (6) @(negedge clock);
    check("notes left", 35'(notes.size()), 35'h0);
    results();
  end
endmodule // test_encoder_control_word_handler
